/* File: rtl/line_enhancement_config_regs.sv */
// Peak trim and enhancement enable registers with their controls
`timescale 1ns/10ps
module line_enhancement_config_regs #(
  parameter bit SELECT_VARIANT = 1'b0,
  parameter int DEB_CYCLES     = line_enh_pkg::DEBOUNCE_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic [7:0]                 addr,
  input  wire logic [7:0]                 wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [7:0]                 rdata,
  input  wire logic                       ringing_relay_bit,
  input  wire logic                       ring_burst_end,
  input  wire logic [7:0]                 programmed_current_limit,
  input  wire logic                       external_battery_mode,
  input  wire logic                       battery_low_request,
  output logic [line_enh_pkg::TRIM_WIDTH-1:0] peak_monitor_trim_value,
  output logic [7:0]                      active_current_limit,
  output logic                            tone1_tick,
  output logic                            tone1_fast_rate,
  output logic [7:0]                      tone1_coefficient,
  output logic [7:0]                      hyst_upper_addr,
  output logic [7:0]                      hyst_lower_addr,
  output logic                            battery_low_select,
  output line_enh_pkg::line_ctrl_t        line_ctrl
);
  import line_enh_pkg::*;

  logic [7:0] peak_current_monitor_trim;
  logic [7:0] feature_enhancement_enable;
  logic       boost_active;
  logic       tick_raw;
  logic       use_low_raw;

  // Address decode and write masking
  wire [7:0] write_mask = SELECT_VARIANT ? SEL_MASK : CONV_MASK;
  wire       hit_trim   = (addr == PEAK_TRIM_ADDR);
  wire       hit_feat   = (addr == FEATURE_EN_ADDR);
  wire       wr_trim    = wr && hit_trim;
  wire       wr_feat    = wr && hit_feat;

  // Named enable bits
  wire post_ring_limit_boost  = feature_enhancement_enable[BIT_LIMIT_BOOST];
  wire fast_tone_clock_enable = feature_enhancement_enable[BIT_FAST_TONE];
  wire battery_switch_debounce = feature_enhancement_enable[BIT_DEBOUNCE];
  wire fast_condition = fast_tone_clock_enable && ringing_relay_bit;

  // Read mux: unmapped addresses answer zero
  wire [7:0] read_value =
    hit_trim ? (peak_current_monitor_trim & TRIM_MASK) :
    hit_feat ? (feature_enhancement_enable & write_mask) :
               8'h00;

  // Register storage; reserved bits are never stored
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      peak_current_monitor_trim  <= PEAK_TRIM_RESET;
      feature_enhancement_enable <= FEATURE_EN_RESET;
    end else begin
      if (wr_trim) peak_current_monitor_trim <= wdata & TRIM_MASK;
      if (wr_feat) feature_enhancement_enable <= wdata & write_mask;
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) rdata <= 8'h00;
    else       rdata <= rd ? read_value : 8'h00;
  end

  // Boost holds from ring burst end until the relay closes again
  always_ff @(posedge clk or posedge reset) begin
    if (reset) boost_active <= 1'b0;
    else if (!post_ring_limit_boost || ringing_relay_bit) boost_active <= 1'b0;
    else if (ring_burst_end) boost_active <= 1'b1;
  end

  tone_tick_gen u_tick (
    .clk   (clk),
    .reset (reset),
    .fast  (fast_condition),
    .tick  (tick_raw)
  );

  battery_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb (
    .clk      (clk),
    .reset    (reset),
    .enable   (battery_switch_debounce),
    .ext_mode (external_battery_mode),
    .want_low (battery_low_request),
    .use_low  (use_low_raw)
  );

  // Controls registered so every output leaves a flip-flop
  wire [7:0] next_limit = boost_active ? BOOST_LIMIT_CODE
                                       : programmed_current_limit;
  wire [7:0] next_coeff = fast_condition ? FSK_COEFF_BASE
                                         : NORMAL_COEFF_BASE;
  line_ctrl_t next_ctrl;
  assign next_ctrl.converter_speedup =
    !SELECT_VARIANT && feature_enhancement_enable[BIT_SPEEDUP];
  assign next_ctrl.ref_resistor_disable =
    feature_enhancement_enable[BIT_REF_DISABLE];
  assign next_ctrl.voltage_loop_closure =
    feature_enhancement_enable[BIT_VOLT_CLOSE];
  assign next_ctrl.converter_squelch =
    !SELECT_VARIANT && feature_enhancement_enable[BIT_SQUELCH];
  assign next_ctrl.closure_hysteresis_enable =
    feature_enhancement_enable[BIT_HYST];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      peak_monitor_trim_value <= PEAK_TRIM_RESET[TRIM_WIDTH-1:0];
      active_current_limit    <= 8'h00;
      tone1_tick              <= 1'b0;
      tone1_fast_rate         <= 1'b0;
      tone1_coefficient       <= NORMAL_COEFF_BASE;
      hyst_upper_addr         <= HYST_UPPER_ADDR;
      hyst_lower_addr         <= HYST_LOWER_ADDR;
      battery_low_select      <= 1'b0;
      line_ctrl               <= '0;
    end else begin
      peak_monitor_trim_value <= peak_current_monitor_trim[TRIM_WIDTH-1:0];
      active_current_limit    <= next_limit;
      tone1_tick              <= tick_raw;
      tone1_fast_rate         <= fast_condition;
      tone1_coefficient       <= next_coeff;
      hyst_upper_addr         <= HYST_UPPER_ADDR;
      hyst_lower_addr         <= HYST_LOWER_ADDR;
      battery_low_select      <= use_low_raw;
      line_ctrl               <= next_ctrl;
    end
  end

  // Checks
  property p_trim_upper_zero;
    @(posedge clk) disable iff (reset)
      (peak_current_monitor_trim & ~TRIM_MASK) == 8'h00;
  endproperty
  a_trim_upper_zero: assert property (p_trim_upper_zero)
    else $error("trim upper bits not zero");

  property p_read_trim;
    @(posedge clk) disable iff (reset)
      rd && hit_trim && !wr |=> rdata == $past(peak_current_monitor_trim);
  endproperty
  a_read_trim: assert property (p_read_trim)
    else $error("trim read mismatch");

  property p_write_feat;
    @(posedge clk) disable iff (reset)
      wr_feat |=> ##1 line_ctrl.voltage_loop_closure ==
                      $past(wdata[BIT_VOLT_CLOSE], 2);
  endproperty
  a_write_feat: assert property (p_write_feat)
    else $error("voltage closure control did not follow write");

  property p_rdata_idle;
    @(posedge clk) disable iff (reset) !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read cycle");

  property p_reserved_bit3;
    @(posedge clk) disable iff (reset)
      !SELECT_VARIANT |-> !feature_enhancement_enable[BIT_DEBOUNCE];
  endproperty
  a_reserved_bit3: assert property (p_reserved_bit3)
    else $error("reserved bit 3 set on converter variant");

  property p_limit_boost;
    @(posedge clk) disable iff (reset)
      boost_active |=> active_current_limit == BOOST_LIMIT_CODE;
  endproperty
  a_limit_boost: assert property (p_limit_boost)
    else $error("boost limit not applied");

  property p_limit_normal;
    @(posedge clk) disable iff (reset)
      !post_ring_limit_boost |=> ##1
        active_current_limit == $past(programmed_current_limit);
  endproperty
  a_limit_normal: assert property (p_limit_normal)
    else $error("programmed limit not applied");

  property p_coeff_sel;
    @(posedge clk) disable iff (reset)
      !fast_tone_clock_enable |=> tone1_coefficient == NORMAL_COEFF_BASE;
  endproperty
  a_coeff_sel: assert property (p_coeff_sel)
    else $error("dedicated coefficients used while disabled");

  property p_fast_rate;
    @(posedge clk) disable iff (reset)
      fast_condition |=> tone1_fast_rate;
  endproperty
  a_fast_rate: assert property (p_fast_rate)
    else $error("fast tone rate not flagged");

  property p_no_debounce;
    @(posedge clk) disable iff (reset)
      !battery_switch_debounce && battery_low_request && !use_low_raw
        |=> ##[1:2] battery_low_select;
  endproperty
  a_no_debounce: assert property (p_no_debounce)
    else $error("low battery delayed without debounce");

  c_write_trim: cover property (@(posedge clk) disable iff (reset) wr_trim);
  c_boost: cover property (@(posedge clk) disable iff (reset) boost_active);
  c_fast: cover property (@(posedge clk) disable iff (reset) fast_condition);
endmodule : line_enhancement_config_regs

/* File: rtl/line_enh_pkg.sv */
// Package: register map, field layout and timing for the enhancement bank
package line_enh_pkg;

  // Register offsets
  localparam logic [7:0] PEAK_TRIM_ADDR   = 8'h6B;
  localparam logic [7:0] FEATURE_EN_ADDR  = 8'h6C;

  // Reset values
  localparam logic [7:0] PEAK_TRIM_RESET  = 8'h08;
  localparam logic [7:0] FEATURE_EN_RESET = 8'h00;

  // Field layout of the peak trim register
  localparam int         TRIM_WIDTH       = 4;
  localparam logic [7:0] TRIM_MASK        = 8'h0F;

  // Bit positions of the enhancement register
  localparam int BIT_LIMIT_BOOST = 7;
  localparam int BIT_FAST_TONE   = 6;
  localparam int BIT_SPEEDUP     = 5;
  localparam int BIT_REF_DISABLE = 4;
  localparam int BIT_DEBOUNCE    = 3;
  localparam int BIT_VOLT_CLOSE  = 2;
  localparam int BIT_SQUELCH     = 1;
  localparam int BIT_HYST        = 0;

  // Writable masks per variant (converter variant: bit 3 reserved)
  localparam logic [7:0] CONV_MASK = 8'hF7;
  localparam logic [7:0] SEL_MASK  = 8'hDD;

  // Timing: clock, tone rates, debounce
  localparam int CLK_HZ        = 40_000_000;
  localparam int SLOW_TONE_HZ  = 8_000;
  localparam int FAST_TONE_HZ  = 24_000;
  localparam int SLOW_DIV      = CLK_HZ / SLOW_TONE_HZ;
  localparam int FAST_DIV      = CLK_HZ / FAST_TONE_HZ;
  localparam int DIV_W         = 13;
  localparam int DEBOUNCE_MS   = 60;
  localparam int DEBOUNCE_CYC  = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int DEB_W         = 22;

  // Current limit code that stands for 41 mA
  localparam logic [7:0] BOOST_LIMIT_CODE = 8'h1F;

  // Indirect coefficient base and hysteresis threshold addresses
  localparam logic [7:0] NORMAL_COEFF_BASE = 8'h0D;
  localparam logic [7:0] FSK_COEFF_BASE    = 8'h63;
  localparam logic [7:0] HYST_UPPER_ADDR   = 8'h1C;
  localparam logic [7:0] HYST_LOWER_ADDR   = 8'h2B;

  // Controls handed to the analog and tone units
  typedef struct packed {
    logic       converter_speedup;
    logic       ref_resistor_disable;
    logic       voltage_loop_closure;
    logic       converter_squelch;
    logic       closure_hysteresis_enable;
  } line_ctrl_t;

  // Battery switch states
  typedef enum logic [1:0] {
    BAT_HIGH = 2'b00,
    BAT_WAIT = 2'b01,
    BAT_LOW  = 2'b11
  } bat_state_t;

endpackage : line_enh_pkg

/* File: rtl/tone_tick_gen.sv */
// Tone generator clock: one-cycle tick at the slow or fast sample rate
`timescale 1ns/10ps
module tone_tick_gen (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic fast,
  output logic      tick
);
  import line_enh_pkg::*;

  logic [DIV_W-1:0] count;
  wire  [DIV_W-1:0] limit = fast ? DIV_W'(FAST_DIV - 1) : DIV_W'(SLOW_DIV - 1);
  wire              wrap  = (count >= limit);

  // Restart on a rate change is implicit: wrap on the compare
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= wrap ? '0 : count + DIV_W'(1);
      tick  <= wrap;
    end
  end
endmodule : tone_tick_gen

/* File: rtl/battery_debounce.sv */
// Battery switch debounce on high-to-low supply transitions
`timescale 1ns/10ps
module battery_debounce #(
  parameter int DEB_CYCLES = line_enh_pkg::DEBOUNCE_CYC
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic enable,
  input  wire logic ext_mode,
  input  wire logic want_low,
  output logic      use_low
);
  import line_enh_pkg::*;

  bat_state_t       state;
  logic [DEB_W-1:0] count;
  wire              slow  = enable && ext_mode;
  wire              done  = (count >= DEB_W'(DEB_CYCLES - 1));

  // Rising supply is never delayed; only the drop to low battery waits
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= BAT_HIGH;
      count <= '0;
    end else begin
      unique case (state)
        BAT_HIGH: begin
          count <= '0;
          if (want_low) state <= slow ? BAT_WAIT : BAT_LOW;
        end
        BAT_WAIT: begin
          count <= count + DEB_W'(1);
          if (!want_low) state <= BAT_HIGH;
          else if (!slow || done) state <= BAT_LOW;
        end
        BAT_LOW: begin
          count <= '0;
          if (!want_low) state <= BAT_HIGH;
        end
        default: state <= BAT_HIGH;
      endcase
    end
  end

  assign use_low = (state == BAT_LOW);
endmodule : battery_debounce

/* File: verification/line_enhancement_config_regs_bench.sv */
// Self-checking bench for the peak trim and enhancement register bank
`timescale 1ns/10ps
module line_enhancement_config_regs_bench;
  import line_enh_pkg::*;
  // Short debounce keeps the run brief; selection variant exposes bit 3
  localparam int DEB = 20;
  logic       clk, reset, wr, rd, relay, burst_end, ext_mode, low_req;
  logic       tick, fast, bat_low;
  logic [7:0] addr, wdata, rdata, limit_in, act_limit, coeff, hup, hlo;
  logic [7:0] trim_m, feat_m, feat_c, rdata2;
  logic [3:0] trim_out;
  line_ctrl_t ctrl, ctrl2;
  int         n_mismatch, checked, seed, c;

  line_enhancement_config_regs #(.SELECT_VARIANT(1'b1), .DEB_CYCLES(DEB))
  u_dut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .ringing_relay_bit(relay),
    .ring_burst_end(burst_end), .programmed_current_limit(limit_in),
    .external_battery_mode(ext_mode), .battery_low_request(low_req),
    .peak_monitor_trim_value(trim_out), .active_current_limit(act_limit),
    .tone1_tick(tick), .tone1_fast_rate(fast), .tone1_coefficient(coeff),
    .hyst_upper_addr(hup), .hyst_lower_addr(hlo),
    .battery_low_select(bat_low), .line_ctrl(ctrl)
  );

  // Converter variant on the same bus: bit 3 reserved, bits 5 and 1 live
  line_enhancement_config_regs #(.SELECT_VARIANT(1'b0), .DEB_CYCLES(DEB))
  u_dut_conv (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata2), .ringing_relay_bit(relay),
    .ring_burst_end(burst_end), .programmed_current_limit(limit_in),
    .external_battery_mode(ext_mode), .battery_low_request(low_req),
    .peak_monitor_trim_value(), .active_current_limit(),
    .tone1_tick(), .tone1_fast_rate(), .tone1_coefficient(),
    .hyst_upper_addr(), .hyst_lower_addr(),
    .battery_low_select(), .line_ctrl(ctrl2)
  );

  // Clock at 40 MHz
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // Port value compare, always four-state
  task automatic chk_out(input logic [7:0] g, input logic [7:0] e,
                         input string what);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask : chk_out

  // Count compare for tick spacing
  task automatic chk_num(input int g, input int e);
    checked++;
    if (g != e) begin
      n_mismatch++;
      $display("BAD %0t tick gap got %0d exp %0d", $time, g, e);
    end
  endtask : chk_num

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  // One-cycle write; the model keeps only the implemented bits
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a == 8'h6B) trim_m = d & 8'h0F;
    if (a == 8'h6C) feat_m = d & 8'hDD;
    if (a == 8'h6C) feat_c = d & 8'hF7;
  endtask : wr_reg

  // One-cycle read; data stand only in the following cycle
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_out(rdata, e, "read");
    chk_out(rdata2, (a == 8'h6C) ? feat_c : e, "read conv");
  endtask : chk_reg

  task automatic chk_ctrl();
    cyc(3);
    chk_out(8'(ctrl), {3'h0, feat_m[5], feat_m[4], feat_m[2:0]}, "ctrl");
    chk_out(8'(ctrl2), {3'h0, feat_c[5], feat_c[4], feat_c[2:0]},
            "ctrl conv");
  endtask : chk_ctrl

  task automatic pulse_end();
    @(posedge clk);
    burst_end <= 1'b1;
    @(posedge clk);
    burst_end <= 1'b0;
    cyc(2);
  endtask : pulse_end

  task automatic wait_tick();
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (tick !== 1'b1 && c < 6000);
  endtask : wait_tick

  // Watchdog sized well above the expected run length
  initial begin
    #(25 * 60000);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    seed = 93;
    {wr, rd, relay, burst_end, ext_mode, low_req} = 6'h00;
    {addr, wdata} = 16'h0000;
    limit_in = 8'h10;
    trim_m = 8'h08;
    feat_m = 8'h00;
    feat_c = 8'h00;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    chk_reg(8'h6B, trim_m);
    chk_reg(8'h6C, feat_m);
    chk_out(8'(trim_out), 8'h08, "trim out");
    chk_out(hup, 8'h1C, "upper thr");
    chk_out(hlo, 8'h2B, "lower thr");
    // Enhancement register: single bits first, then random patterns; trim random throughout; each read back at once
    for (int i = 0; i < 16; i++) begin
      wr_reg(8'h6B, 8'($random(seed)));
      chk_reg(8'h6B, trim_m);
      chk_out(8'(trim_out), trim_m, "trim out");
      wr_reg(8'h6C, (i < 8) ? 8'(1 << i) : 8'($random(seed)));
      chk_reg(8'h6C, feat_m);
      chk_ctrl();
    end
    cyc(1);
    chk_out(rdata, 8'h00, "rdata idle");
    // Unmapped place reads zero and leaves the enhancement register alone
    wr_reg(8'h6D, 8'hFF);
    chk_reg(8'h6D, 8'h00);
    chk_reg(8'h6C, feat_m);
    // Limit boost at ring burst end, only while enabled
    wr_reg(8'h6C, 8'h80);
    limit_in <= 8'($random(seed));
    pulse_end();
    chk_out(act_limit, BOOST_LIMIT_CODE, "boost");
    wr_reg(8'h6C, 8'h00);
    cyc(2);
    chk_out(act_limit, limit_in, "limit");
    pulse_end();
    chk_out(act_limit, limit_in, "no boost");
    // Tone rate and coefficients over enable and relay
    for (int m = 0; m < 3; m++) begin
      wr_reg(8'h6C, (m > 0) ? 8'h40 : 8'h00);
      relay <= (m != 1);
      cyc(3);
      chk_out(8'(fast), 8'(m == 2), "fast");
      chk_out(coeff, (m == 2) ? 8'h63 : NORMAL_COEFF_BASE, "coef");
      wait_tick();
      wait_tick();
      wait_tick();
      chk_num(c, (m == 2) ? CLK_HZ / 24000 : CLK_HZ / 8000);
    end
    // Debounce only with the bit set and external battery mode
    for (int m = 0; m < 3; m++) begin
      wr_reg(8'h6C, (m > 0) ? 8'h08 : 8'h00);
      ext_mode <= (m < 2);
      low_req  <= 1'b0;
      cyc(DEB + 8);
      @(posedge clk);
      low_req <= 1'b1;
      cyc(5);
      chk_out(8'(bat_low), 8'(m != 1), "low early");
      cyc(DEB + 5);
      chk_out(8'(bat_low), 8'h01, "low late");
      @(posedge clk);
      low_req <= 1'b0;
      cyc(5);
      chk_out(8'(bat_low), 8'h00, "back high");
    end
    // Reset in mid-run restores both registers
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    feat_c = 8'h00;
    chk_reg(8'h6B, 8'h08);
    chk_reg(8'h6C, 8'h00);
    chk_out(8'(trim_out), 8'h08, "trim after reset");
    print_verdict();
  end
endmodule : line_enhancement_config_regs_bench
